/* File: src/oevt_pkg.sv */
// Constants for the OTG line event enable block.
// Assumes register cycles are decoded to a byte-wide strobe port upstream.
// Summary of operation
// R1 - Enabled rising source change raises interrupt and RXCMD
// R2 - Enabled falling source change raises interrupt and RXCMD
// R3 - Enables reset to 1Fh, upper bits zero
// R4 - Rising enables: read 0Dh-0Fh, write/set/clear aliases
// R5 - Falling enables: read 10h-12h, write/set/clear aliases
// R6 - Status at 13h, live bits 4:0, reset zero
// R7 - Bit 4 is ID ground source
// R8 - Bit 3 is session end source
// R9 - Bit 2 is session valid source
// R10 - Bit 1 is bus power valid source
// R11 - Bit 0 is host disconnect source
// R12 - Rise and fall enables act independently
// R13 - Latch at 14h; cleared by read, low power
// R14 - Set alias ORs, clear alias clears ones
// R15 - Link writes zero to reserved bits
package oevt_pkg;
  localparam logic [5:0] ADDR_RISE_WRITE  = 6'h0d;
  localparam logic [5:0] ADDR_RISE_SET    = 6'h0e;
  localparam logic [5:0] ADDR_RISE_CLEAR  = 6'h0f;
  localparam logic [5:0] ADDR_FALL_WRITE  = 6'h10;
  localparam logic [5:0] ADDR_FALL_SET    = 6'h11;
  localparam logic [5:0] ADDR_FALL_CLEAR  = 6'h12;
  localparam logic [5:0] ADDR_STATUS      = 6'h13;
  localparam logic [5:0] ADDR_LATCH       = 6'h14;
  localparam logic [7:0] ENABLE_RESET     = 8'h1f;
  localparam logic [4:0] STATUS_RESET     = 5'h00;
  localparam logic [4:0] LATCH_RESET      = 5'h00;
  localparam int         BIT_ID_GROUND    = 4;
  localparam int         BIT_SESSION_END  = 3;
  localparam int         BIT_SESSION_VLD  = 2;
  localparam int         BIT_BUS_POWER    = 1;
  localparam int         BIT_HOST_DISC    = 0;
endpackage

/* File: src/oevt_enable_reg.sv */
// One event enable byte with write, set and clear aliases.
// Assumes write strobes are one-cycle pulses on i_clock.
`timescale 1ns/1ns
module oevt_enable_reg #(
  parameter logic [5:0] ADDR_WRITE = 6'h00,
  parameter logic [5:0] ADDR_SET   = 6'h01,
  parameter logic [5:0] ADDR_CLEAR = 6'h02
) (
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  input  wire logic       i_wr,
  input  wire logic [5:0] i_addr,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_value
);
  typedef struct packed {
    logic [7:0] value;
  } oevt_enable_s;

  oevt_enable_s state_q;
  oevt_enable_s state_d;

  // Alias decode of one write
  function automatic logic [7:0] apply_write(input logic [7:0] cur,
                                             input logic [5:0] addr,
                                             input logic [7:0] data);
    logic [7:0] res;
    res = cur;
    if (addr == ADDR_WRITE) begin
      res = data;
    end else if (addr == ADDR_SET) begin
      res = cur | data;
    end else if (addr == ADDR_CLEAR) begin
      res = cur & ~data;
    end
    return res;
  endfunction

  always_comb begin
    state_d = state_q;
    if (i_wr) begin
      state_d.value = apply_write(state_q.value, i_addr, i_wdata); // see R14
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_q.value <= oevt_pkg::ENABLE_RESET; // see R3
    end else begin
      state_q <= state_d;
    end
  end

  assign o_value = state_q.value;

  property p_reset_value;
    @(posedge i_clock) $fell(i_rst) |-> o_value == 8'h1f;
  endproperty
  a_reset_value: assert property (p_reset_value) // see R3
    else $error("Enable byte not 1Fh after reset");

  property p_set_alias;
    @(posedge i_clock) disable iff (i_rst)
      (i_wr && i_addr == ADDR_SET) |=>
        o_value == ($past(o_value) | $past(i_wdata));
  endproperty
  a_set_alias: assert property (p_set_alias) // see R14
    else $error("Set alias did not OR data in");

  property p_clear_alias;
    @(posedge i_clock) disable iff (i_rst)
      (i_wr && i_addr == ADDR_CLEAR) |=>
        o_value == ($past(o_value) & ~$past(i_wdata));
  endproperty
  a_clear_alias: assert property (p_clear_alias) // see R14
    else $error("Clear alias did not clear ones");
endmodule

/* File: src/oevt_event_enables.sv */
// OTG line event status, edge enables, latch and RXCMD request.
// Assumes source inputs and register strobes are synchronous to i_clock.
`timescale 1ns/1ns
module oevt_event_enables (
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  input  wire logic       i_id_pin_grounded,
  input  wire logic       i_session_ended_flag,
  input  wire logic       i_session_valid_comparator,
  input  wire logic       i_bus_power_valid_comparator,
  input  wire logic       i_host_disconnect_flag,
  input  wire logic       i_low_power,
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  input  wire logic [5:0] i_reg_addr,
  input  wire logic [7:0] i_reg_wdata,
  output logic      [7:0] o_reg_rdata,
  output logic            o_reg_rvalid,
  output logic            o_event_irq,
  output logic            o_rxcmd_valid,
  output logic      [4:0] o_rxcmd_status,
  output logic      [4:0] o_event_latch
);
  typedef struct packed {
    logic [4:0] status;
    logic [4:0] latch;
    logic [7:0] rdata;
    logic       rvalid;
    logic       irq;
    logic       rxcmd_valid;
    logic [4:0] rxcmd_status;
  } oevt_top_s;

  oevt_top_s  st_q;
  oevt_top_s  st_d;
  logic [7:0] rise_en;
  logic [7:0] fall_en;
  logic [4:0] src;
  logic [4:0] events;

  oevt_enable_reg #(
    .ADDR_WRITE (oevt_pkg::ADDR_RISE_WRITE),
    .ADDR_SET   (oevt_pkg::ADDR_RISE_SET),
    .ADDR_CLEAR (oevt_pkg::ADDR_RISE_CLEAR)
  ) u_rise (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_wr    (i_reg_wr),
    .i_addr  (i_reg_addr),
    .i_wdata (i_reg_wdata),
    .o_value (rise_en)
  );

  oevt_enable_reg #(
    .ADDR_WRITE (oevt_pkg::ADDR_FALL_WRITE),
    .ADDR_SET   (oevt_pkg::ADDR_FALL_SET),
    .ADDR_CLEAR (oevt_pkg::ADDR_FALL_CLEAR)
  ) u_fall (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_wr    (i_reg_wr),
    .i_addr  (i_reg_addr),
    .i_wdata (i_reg_wdata),
    .o_value (fall_en)
  );

  // Source bit placement
  always_comb begin
    src = '0;
    src[oevt_pkg::BIT_ID_GROUND]   = i_id_pin_grounded;            // see R7
    src[oevt_pkg::BIT_SESSION_END] = i_session_ended_flag;         // see R8
    src[oevt_pkg::BIT_SESSION_VLD] = i_session_valid_comparator;   // see R9
    src[oevt_pkg::BIT_BUS_POWER]   = i_bus_power_valid_comparator; // see R10
    src[oevt_pkg::BIT_HOST_DISC]   = i_host_disconnect_flag;       // see R11
  end

  // Qualified edges per source
  assign events = (src & ~st_q.status & rise_en[4:0])   // see R1, R12
                | (~src & st_q.status & fall_en[4:0]);  // see R2, R12

  always_comb begin
    st_d             = st_q;
    st_d.status      = src;                              // see R6
    st_d.irq         = |events;                          // see R1, R2
    st_d.rxcmd_valid = |events;
    st_d.rxcmd_status = src;
    st_d.rvalid      = i_reg_rd;
    // Latch clear on read or low power; new events win
    if ((i_reg_rd && i_reg_addr == oevt_pkg::ADDR_LATCH) || i_low_power) begin
      st_d.latch = events;                               // see R13
    end else begin
      st_d.latch = st_q.latch | events;                  // see R13
    end
    if (i_reg_rd) begin
      case (i_reg_addr)
        oevt_pkg::ADDR_RISE_WRITE,
        oevt_pkg::ADDR_RISE_SET,
        oevt_pkg::ADDR_RISE_CLEAR: begin
          st_d.rdata = rise_en;                          // see R4
        end
        oevt_pkg::ADDR_FALL_WRITE,
        oevt_pkg::ADDR_FALL_SET,
        oevt_pkg::ADDR_FALL_CLEAR: begin
          st_d.rdata = fall_en;                          // see R5
        end
        oevt_pkg::ADDR_STATUS: begin
          st_d.rdata = {3'h0, st_q.status};              // see R6
        end
        oevt_pkg::ADDR_LATCH: begin
          st_d.rdata = {3'h0, st_q.latch};               // see R13
        end
        default: begin
          st_d.rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      st_q.status       <= oevt_pkg::STATUS_RESET;       // see R6
      st_q.latch        <= oevt_pkg::LATCH_RESET;
      st_q.rdata        <= 8'h00;
      st_q.rvalid       <= 1'b0;
      st_q.irq          <= 1'b0;
      st_q.rxcmd_valid  <= 1'b0;
      st_q.rxcmd_status <= 5'h00;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_reg_rdata    = st_q.rdata;
  assign o_reg_rvalid   = st_q.rvalid;
  assign o_event_irq    = st_q.irq;
  assign o_rxcmd_valid  = st_q.rxcmd_valid;
  assign o_rxcmd_status = st_q.rxcmd_status;
  assign o_event_latch  = st_q.latch;

  property p_rise_event;
    @(posedge i_clock) disable iff (i_rst)
      (|(src & ~st_q.status & rise_en[4:0])) |=> o_event_irq && o_rxcmd_valid;
  endproperty
  a_rise_event: assert property (p_rise_event) // see R1
    else $error("Enabled rise gave no interrupt");

  property p_fall_event;
    @(posedge i_clock) disable iff (i_rst)
      (|(~src & st_q.status & fall_en[4:0])) |=> o_event_irq && o_rxcmd_valid;
  endproperty
  a_fall_event: assert property (p_fall_event) // see R2
    else $error("Enabled fall gave no interrupt");

  property p_no_unqualified;
    @(posedge i_clock) disable iff (i_rst)
      (((src & ~st_q.status & ~rise_en[4:0]) |
        (~src & st_q.status & ~fall_en[4:0])) == (src ^ st_q.status))
        |=> !o_event_irq;
  endproperty
  a_no_unqualified: assert property (p_no_unqualified) // see R12
    else $error("Interrupt from a disabled edge");

  property p_status_follows;
    @(posedge i_clock) disable iff (i_rst)
      1'b1 |=> st_q.status == {$past(i_id_pin_grounded),
        $past(i_session_ended_flag), $past(i_session_valid_comparator),
        $past(i_bus_power_valid_comparator), $past(i_host_disconnect_flag)};
  endproperty
  a_status_follows: assert property (p_status_follows) // see R7
    else $error("Status does not follow sources");

  property p_status_read;
    @(posedge i_clock) disable iff (i_rst)
      (i_reg_rd && i_reg_addr == 6'h13) |=>
        o_reg_rvalid && o_reg_rdata == {3'h0, $past(st_q.status)};
  endproperty
  a_status_read: assert property (p_status_read) // see R6
    else $error("Status read returned wrong byte");

  property p_rise_read;
    @(posedge i_clock) disable iff (i_rst)
      (i_reg_rd && i_reg_addr == 6'h0f) |=> o_reg_rdata == $past(rise_en);
  endproperty
  a_rise_read: assert property (p_rise_read) // see R4
    else $error("Rise enable read at clear alias wrong");

  property p_fall_read;
    @(posedge i_clock) disable iff (i_rst)
      (i_reg_rd && i_reg_addr == 6'h11) |=> o_reg_rdata == $past(fall_en);
  endproperty
  a_fall_read: assert property (p_fall_read) // see R5
    else $error("Fall enable read at set alias wrong");

  property p_rise_load;
    @(posedge i_clock) disable iff (i_rst)
      (i_reg_wr && i_reg_addr == oevt_pkg::ADDR_RISE_WRITE) |=>
        rise_en == $past(i_reg_wdata);
  endproperty
  a_rise_load: assert property (p_rise_load) // see R4
    else $error("Rise enable write not loaded");

  property p_fall_load;
    @(posedge i_clock) disable iff (i_rst)
      (i_reg_wr && i_reg_addr == oevt_pkg::ADDR_FALL_WRITE) |=>
        fall_en == $past(i_reg_wdata);
  endproperty
  a_fall_load: assert property (p_fall_load) // see R5
    else $error("Fall enable write not loaded");

  property p_latch_read;
    @(posedge i_clock) disable iff (i_rst)
      (i_reg_rd && i_reg_addr == oevt_pkg::ADDR_LATCH) |=>
        o_reg_rdata == {3'h0, $past(o_event_latch)};
  endproperty
  a_latch_read: assert property (p_latch_read) // see R13
    else $error("Latch read returned wrong byte");

  property p_latch_clear;
    @(posedge i_clock) disable iff (i_rst)
      ((i_reg_rd && i_reg_addr == 6'h14) || i_low_power) && events == 5'h00
        |=> o_event_latch == 5'h00;
  endproperty
  a_latch_clear: assert property (p_latch_clear) // see R13
    else $error("Latch not cleared by read or low power");

  property p_latch_set;
    @(posedge i_clock) disable iff (i_rst)
      events != 5'h00 |=> (o_event_latch & $past(events)) == $past(events);
  endproperty
  a_latch_set: assert property (p_latch_set) // see R13
    else $error("Event did not set its latch bit");
endmodule

/* File: test/oevt_link_model.sv */
// Link controller model: register cycles and RXCMD counting.
// Assumes read data answers within a few cycles of the strobe.
`timescale 1ns/1ns
module oevt_link_model (
  input  wire logic       i_clock,
  input  wire logic [7:0] i_reg_rdata,
  input  wire logic       i_reg_rvalid,
  input  wire logic       i_rxcmd_valid,
  output logic            o_reg_wr,
  output logic            o_reg_rd,
  output logic      [5:0] o_reg_addr,
  output logic      [7:0] o_reg_wdata,
  output int              o_rxcmd_count
);
  initial begin
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_addr = 6'h3f;
    o_reg_wdata = 8'hff;
    o_rxcmd_count = 0;
  end
  // Counts RXCMD requests
  always @(posedge i_clock) begin
    if (i_rxcmd_valid === 1'b1) begin
      o_rxcmd_count <= o_rxcmd_count + 1;
    end
  end
  // Upper bits zero during the write strobe; idle bus shows inverted values
  task automatic wr(input logic [5:0] a, input logic [4:0] d);
    @(posedge i_clock);
    o_reg_wr <= 1'b1;
    o_reg_addr <= a;
    o_reg_wdata <= {3'h0, d};
    @(posedge i_clock);
    o_reg_wr <= 1'b0;
    o_reg_addr <= ~a;
    o_reg_wdata <= ~{3'h0, d};
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d, output bit ok);
    ok = 1'b0;
    d = 8'h00;
    @(posedge i_clock);
    o_reg_rd <= 1'b1;
    o_reg_addr <= a;
    @(posedge i_clock);
    o_reg_rd <= 1'b0;
    o_reg_addr <= ~a;
    for (int n = 0; n < 4 && !ok; n++) begin
      @(posedge i_clock);
      if (i_reg_rvalid === 1'b1) begin
        ok = 1'b1;
        d = i_reg_rdata;
      end
    end
  endtask
endmodule

/* File: test/oevt_event_enables_tb_top.sv */
// Testbench for the OTG line event enable block.
// Assumes the link model drives all register strobes.
`timescale 1ns/1ns
module oevt_event_enables_tb_top;
  logic       clock;
  logic       rst;
  logic       lp;
  logic [4:0] srcs;
  logic       wr;
  logic       rd;
  logic [5:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       rvalid;
  logic       irq;
  logic       rxv;
  logic [4:0] stat;
  logic [4:0] lat;
  int         cnt;
  int         n_exp;
  int         n_tests;
  int         n_mismatch;

  oevt_event_enables dut (
    .i_clock(clock), .i_rst(rst),
    .i_id_pin_grounded(srcs[4]), .i_session_ended_flag(srcs[3]),
    .i_session_valid_comparator(srcs[2]),
    .i_bus_power_valid_comparator(srcs[1]),
    .i_host_disconnect_flag(srcs[0]), .i_low_power(lp),
    .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .o_event_irq(irq),
    .o_rxcmd_valid(rxv), .o_rxcmd_status(stat), .o_event_latch(lat)
  );
  oevt_link_model link (
    .i_clock(clock), .i_reg_rdata(rdata), .i_reg_rvalid(rvalid),
    .i_rxcmd_valid(rxv), .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_addr(addr),
    .o_reg_wdata(wdata), .o_rxcmd_count(cnt)
  );

  initial clock = 1'b0;
  always #10 clock = ~clock;

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    n_tests++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // Register read with bounded wait
  task automatic rchk(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] d;
    bit         ok;
    link.rd(a, d, ok);
    if (!ok) begin
      n_mismatch++;
      $display("ERROR read valid at %h expected 1 seen 0", a);
      complete_run();
    end else begin
      chk($sformatf("reg %h", a), e, d);
    end
  endtask
  // Source change, then pulse and status check
  task automatic src(input logic [4:0] v, input logic e);
    logic [4:0] chg;
    chg = v ^ srcs;
    @(posedge clock);
    srcs <= v;
    @(posedge clock);
    @(posedge clock);
    if (e) n_exp++;
    chk("irq", {7'h0, e}, {7'h0, irq});
    chk("rxcmd", {7'h0, e}, {7'h0, rxv});
    chk("status", {3'h0, v}, {3'h0, stat});
    if (e) chk("latch", {3'h0, chg}, {3'h0, lat & chg});
  endtask

  initial begin
    rst = 1'b1;
    lp = 1'b0;
    srcs = 5'h00;
    n_exp = 0;
    n_tests = 0;
    n_mismatch = 0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    for (int a = 13; a <= 18; a++) rchk(a[5:0], 8'h1f);
    rchk(6'h13, 8'h00);
    rchk(6'h14, 8'h00);
    for (int i = 0; i < 5; i++) begin
      src(5'h01 << i, 1'b1);
      rchk(6'h13, 8'h01 << i);
      rchk(6'h14, 8'h01 << i);
      src(5'h00, 1'b1);
      rchk(6'h14, 8'h01 << i);
    end
    rchk(6'h14, 8'h00);
    link.wr(6'h0d, 5'h00);
    rchk(6'h0f, 8'h00);
    src(5'h04, 1'b0);
    src(5'h00, 1'b1);
    link.wr(6'h0e, 5'h04);
    rchk(6'h0d, 8'h04);
    src(5'h04, 1'b1);
    link.wr(6'h12, 5'h04);
    rchk(6'h11, 8'h1b);
    src(5'h00, 1'b0);
    rchk(6'h14, 8'h04);
    link.wr(6'h11, 5'h04);
    src(5'h04, 1'b1);
    @(posedge clock) lp <= 1'b1;
    @(posedge clock) lp <= 1'b0;
    rchk(6'h14, 8'h00);
    src(5'h00, 1'b1);
    link.wr(6'h0f, 5'h1f);
    rchk(6'h0e, 8'h00);
    link.wr(6'h10, 5'h0a);
    rchk(6'h12, 8'h0a);
    rchk(6'h20, 8'h00);
    link.wr(6'h13, 5'h1f);
    rchk(6'h13, 8'h00);
    chk("rxcmd count", n_exp[7:0], cnt[7:0]);
    complete_run();
  end
endmodule
